// ---- rtl/stab_pkg.sv ----
package stab_pkg;
  // ----------------------------------------
  // Status layout and selection
  // ----------------------------------------
  localparam int STATUS_W = 8;
  localparam int SEL_W = 3;
  // Count exponent of the first status bit; each later bit adds one to it
  localparam int FIRST_SHIFT = 9;
  localparam int CNT_W = FIRST_SHIFT + STATUS_W;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RESET = 17'h0_0000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 17'h0_0001;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_HZ = 20_000_000;
  localparam int MIN_TIME_US = 20;
  // Shortest legal wait in clock cycles, rounded down
  localparam int MIN_CYCLES = (MIN_TIME_US * (CLOCK_HZ / 1_000_000) + 0);

  // Count at which status bit idx becomes 1
  function automatic logic [CNT_W-1:0] threshold(input logic [SEL_W-1:0] idx);
    threshold = COUNT_ONE << (FIRST_SHIFT + int'(idx));
  endfunction : threshold
endpackage : stab_pkg

// ---- rtl/stab_if.sv ----
`timescale 1ns/1ps
interface stab_if;
  import stab_pkg::*;
  logic [CNT_W-1:0] count;
  logic [SEL_W-1:0] select;
  logic [STATUS_W-1:0] ladder;
  logic at_target;
  modport counter (output count, output select, input ladder, input at_target);
  modport decode (input count, input select, output ladder, output at_target);
endinterface : stab_if

// ---- rtl/status_ladder.sv ----
`timescale 1ns/1ps
module status_ladder
  import stab_pkg::*;
(
  stab_if.decode bus
);
  // ----------------------------------------
  // Threshold decode
  // ----------------------------------------
  // Bit k passed only while k is within the selected time
  genvar k;
  for (k = 0; k < STATUS_W; k++) begin : g_bit
    localparam logic [SEL_W-1:0] IDX = SEL_W'(k);
    wire reached = bus.count >= threshold(IDX);
    assign bus.ladder[k] = reached && (IDX <= bus.select);
  end

  // End of count at the selected time
  assign bus.at_target = bus.count >= threshold(bus.select);
endmodule : status_ladder

// ---- rtl/oscillation_stabilization_counter.sv ----
`timescale 1ns/1ps
// How it works
// - Status bits become 1 in order from the first bit and stay 1.
// - Counter counts up only until the selected stabilization time, then stops.
// - After a stop release, status shows only up to the selected time.
// - Counting starts only once the main oscillator is actually oscillating.
module oscillation_stabilization_counter
  import stab_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clock_enable,
  input wire logic osc_start,
  input wire logic stop_release,
  input wire logic osc_present,
  input wire logic [SEL_W-1:0] stabilization_time_select,
  output logic [STATUS_W-1:0] stabilization_status_register,
  output logic stabilization_done
);
  // ----------------------------------------
  // Behaviour notes
  // ----------------------------------------
  // The counter starts from zero on every oscillator start and on every
  // stop release. It only advances while the synchronised presence flag
  // is high. The time before the oscillator really swings is therefore
  // never counted. A missing oscillator freezes the count without
  // clearing it, so a late start resumes where it stopped.
  //
  // Status bit k becomes 1 one edge after the count reaches its
  // threshold, as long as k is not above the live select. Thresholds
  // double from bit to bit, and the first one is 512 cycles. At the
  // 50 ns clock that is well above the shortest legal wait. Bits are
  // only ever ORed in, so once set they stay set until the next restart.
  //
  // The select is read live and is not latched. Lowering it below the
  // current count ends the wait at once. Raising it mid-count lets the
  // counter run on. Both are software's business; the status never
  // shows a bit above the select that it had when that bit was set.
  //
  // Clock enable low holds every flop, including the synchroniser, so
  // a frozen clock domain neither counts nor loses presence history.
  //
  // A restart in the same cycle as a new status bit wins: restart
  // means the wait begins again, so no stale bit may survive it.

  stab_if bus ();

  logic osc_meta;
  logic osc_seen;
  logic [CNT_W-1:0] count;

  // ----------------------------------------
  // Threshold decode
  // ----------------------------------------
  status_ladder u_ladder (
    .bus(bus.decode)
  );

  assign bus.count = count;
  assign bus.select = stabilization_time_select;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Restart on oscillator start or stop release
  wire restart = osc_start || stop_release;
  wire advance = osc_seen && !bus.at_target;
  wire [CNT_W-1:0] next_count = restart ? COUNT_RESET :
                                advance ? CNT_W'(count + COUNT_ONE) : count;
  wire [STATUS_W-1:0] next_status = restart ? STATUS_RESET :
                                    (stabilization_status_register | bus.ladder);
  wire next_done = !restart && bus.at_target;

  // ----------------------------------------
  // Oscillation-present synchroniser
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      osc_meta <= 1'b0;
      osc_seen <= 1'b0;
    end else if (clock_enable) begin
      osc_meta <= osc_present;
      osc_seen <= osc_meta;
    end
  end

  // ----------------------------------------
  // Counter and status
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= COUNT_RESET;
      stabilization_status_register <= STATUS_RESET;
      stabilization_done <= 1'b0;
    end else if (clock_enable) begin
      count <= next_count;
      stabilization_status_register <= next_status;
      stabilization_done <= next_done;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Status bits never fall without a restart
  status_sticky_a: assert property (@(posedge clock) disable iff (srst)
    !$past(restart) && $past(clock_enable) |->
      ((stabilization_status_register & $past(stabilization_status_register))
        == $past(stabilization_status_register)))
    else $error("status bit cleared without restart");

  // Status fills from the first bit upward
  status_order_a: assert property (@(posedge clock) disable iff (srst)
    ((stabilization_status_register & (stabilization_status_register + 8'h01)) == 8'h00))
    else $error("status bits not contiguous from first bit");

  // Counter holds once the selected time is reached
  count_stop_a: assert property (@(posedge clock) disable iff (srst)
    clock_enable && !restart && bus.at_target |=> $stable(count))
    else $error("counter ran past selected time");

  // Counter never exceeds the selected threshold unless the select is lowered below the count
  count_bound_a: assert property (@(posedge clock) disable iff (srst)
    $stable(stabilization_time_select) |-> count <= threshold(stabilization_time_select))
    else $error("counter above selected threshold");

  // Status limited to the selected time
  status_limit_a: assert property (@(posedge clock) disable iff (srst)
    ($stable(stabilization_time_select) && !$past(restart)) |->
      ((stabilization_status_register >> stabilization_time_select) <= 8'h01))
    else $error("status beyond selected time");

  // No counting without oscillation
  count_gate_a: assert property (@(posedge clock) disable iff (srst)
    clock_enable && !restart && !osc_seen |=> $stable(count))
    else $error("counted without oscillation");

  // Counter advances by one each edge while oscillation is seen and the target is not reached
  count_start_a: assert property (@(posedge clock) disable iff (srst)
    clock_enable && !restart && osc_seen && !bus.at_target |=> count == $past(count) + 17'h0_0001)
    else $error("counter did not advance");

  // Restart clears counter, status and done
  restart_clear_a: assert property (@(posedge clock) disable iff (srst)
    clock_enable && restart |=> (count == COUNT_RESET) &&
      (stabilization_status_register == STATUS_RESET) && !stabilization_done)
    else $error("restart did not clear state");

  // Done follows the target one edge later
  done_set_a: assert property (@(posedge clock) disable iff (srst)
    clock_enable && !restart && bus.at_target |=> stabilization_done)
    else $error("done missing after target reached");

  // Done stays while the select is unchanged
  done_hold_a: assert property (@(posedge clock) disable iff (srst)
    clock_enable && !restart && stabilization_done && $stable(stabilization_time_select)
      |=> stabilization_done)
    else $error("done dropped without restart");

  // Enable low freezes counter, status and done
  enable_freeze_a: assert property (@(posedge clock) disable iff (srst)
    !clock_enable |=> $stable(count) && $stable(stabilization_status_register) &&
      $stable(stabilization_done))
    else $error("state moved while enable low");

  // Presence flag moves from the first stage to the second
  sync_pass_a: assert property (@(posedge clock) disable iff (srst)
    clock_enable |=> (osc_seen == $past(osc_meta)))
    else $error("presence flag skipped a stage");

  // First bit set once its threshold passes
  first_bit_a: assert property (@(posedge clock) disable iff (srst)
    clock_enable && !restart && (count >= threshold(3'h0)) |=>
      stabilization_status_register[0])
    else $error("first status bit not set");

  // Any set bit implies the first bit
  first_low_a: assert property (@(posedge clock) disable iff (srst)
    (stabilization_status_register != STATUS_RESET) |-> stabilization_status_register[0])
    else $error("status set without first bit");
endmodule : oscillation_stabilization_counter

// ---- dv/oscillation_stabilization_counter_test.sv ----
`timescale 1ns/1ps
module oscillation_stabilization_counter_test;
  import stab_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clock_enable = 1'b1;
  logic osc_start = 1'b0;
  logic stop_release = 1'b0;
  logic osc_present = 1'b0;
  logic [SEL_W-1:0] sel = 3'h0;
  logic [STATUS_W-1:0] status;
  logic done;
  int failures = 0;
  int samples_checked = 0;
  int n;
  // ----------------------------------------
  // Clock and design
  // ----------------------------------------
  always #25 clock = ~clock;
  oscillation_stabilization_counter oscillation_stabilization_counter_inst (
    .clock(clock), .srst(srst), .clock_enable(clock_enable), .osc_start(osc_start),
    .stop_release(stop_release), .osc_present(osc_present),
    .stabilization_time_select(sel), .stabilization_status_register(status),
    .stabilization_done(done));
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Status expected once the selected time is reached
  function automatic logic [31:0] mask(input int s);
    mask = (32'h0000_0001 << (s + 1)) - 32'h0000_0001;
  endfunction : mask
  task automatic final_report;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Restart pulse with a new select
  task automatic restart(input int s, input logic stop);
    @(posedge clock);
    sel <= SEL_W'(s);
    osc_start <= ~stop;
    stop_release <= stop;
    @(posedge clock);
    osc_start <= 1'b0;
    stop_release <= 1'b0;
    @(posedge clock);
    #1;
    check(status, 0);
    check(done, 0);
  endtask : restart
  // Wait for the target, then check status and that it holds
  task automatic finish(input int s);
    n = 0;
    while (done !== 1'b1 && n < 70000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n >= (1 << (FIRST_SHIFT + s)) && n <= (1 << (FIRST_SHIFT + s)) + 6, 1);
    if (n >= 70000) final_report();
    check(status, mask(s));
    repeat (50) @(posedge clock);
    #1;
    check(status, mask(s));
  endtask : finish
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n = $urandom(32'hd3e0);
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    osc_present <= 1'b1;
    restart(0, 1'b0);
    finish(0);
    restart(2, 1'b1);
    finish(2);
    restart(3, 1'b0);
    finish(3);
    check((32'h0000_0001 << FIRST_SHIFT) > MIN_CYCLES, 1);
    repeat (4) begin
      restart(1 + ($urandom % 2), $urandom % 2);
      finish(sel);
    end
    // Enable low freezes the count part way
    restart(0, 1'b0);
    repeat (100) @(posedge clock);
    clock_enable <= 1'b0;
    repeat (700) @(posedge clock);
    #1;
    check(done, 0);
    check(status, 0);
    @(posedge clock);
    clock_enable <= 1'b1;
    repeat (600) @(posedge clock);
    #1;
    check(status, mask(0));
    check(done, 1);
    // Mid-run reset clears everything
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check(status, 0);
    check(done, 0);
    // Oscillator absent: no counting until it appears
    @(posedge clock);
    osc_present <= 1'b0;
    restart(0, 1'b0);
    repeat (600) @(posedge clock);
    #1;
    check(status, 0);
    check(done, 0);
    @(posedge clock);
    osc_present <= 1'b1;
    finish(0);
    final_report();
  end
endmodule : oscillation_stabilization_counter_test
